/* core/regulator_control.sv */
// Step-down regulator control, sync clock generation and register slave
`timescale 1ns/1ps

module regulator_control
    import regulator_control_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire avm_req_t bus_req,
    output avm_rsp_t bus_rsp,
    input wire logic [NUM_REG-1:0][7:0] otp_voltage,
    input wire logic [NUM_REG-1:0] otp_seq_en,
    input wire logic [NUM_REG-1:0][2:0] otp_slot,
    input wire logic sleep_request_pin_n,
    input wire logic resource_enable_pin_one,
    input wire logic warm_reset_pin,
    input wire logic switcher_sync_clock_in,
    input wire logic supply_below_limit,
    input wire logic [NUM_REG-1:0] rail_in_window,
    output reg_cmd_t [NUM_REG-1:0] reg_cmd,
    output logic [NUM_PHASE-1:0] phase_clk,
    output logic output_ok_flag,
    output logic clk32k_enable,
    output logic [2:0] gpo_enable,
    output logic general_pin_five_o,
    output logic general_pin_five_oe
);

    // ======================================================================
    // State
    localparam int SI_SLEEP = 0;
    localparam int SI_EN1 = 1;
    localparam int SI_WARM = 2;
    localparam int SI_SUPPLY = 3;
    localparam int SI_SYNC = 4;

    typedef struct packed {
        logic [NUM_REG-1:0][7:0] ctrl;
        logic [NUM_REG-1:0][7:0] volt;
        logic [NUM_REG-1:0] pd;
        logic [2:0] mon;
        logic [NUM_RES-1:0] slp_asg;
        logic [NUM_RES-1:0] en1_asg;
        logic [4:0] sys;
        seq_state_t seq;
        logic [7:0] slot_cyc;
        logic [2:0] slot;
        logic [NUM_REG-1:0][11:0] blank;
        logic [NUM_REG-1:0] trip;
        logic [4:0] s1;
        logic [4:0] s2;
        logic [NUM_REG-1:0] win1;
        logic [NUM_REG-1:0] win2;
        logic sync_prev;
        logic warm_prev;
        logic [8:0] meas;
        logic [8:0] last_period;
        logic sync_ok;
        logic sat_hi;
        logic sat_lo;
        logic [7:0] period;
        logic [7:0] phase_cnt;
        logic [7:0] rc_cnt;
        logic rc_clk;
        logic [NUM_PHASE-1:0] sw_clk;
        reg_cmd_t [NUM_REG-1:0] cmd;
        logic [NUM_REG-1:0] rail_ok;
        logic ok_flag;
        logic clk32k_en;
        logic [2:0] gpo_en;
        logic pin5_o;
        logic pin5_oe;
        avm_rsp_t rsp;
    } state_t;

    state_t q;
    state_t n;

    logic [NUM_REG-1:0] sel_sleep;
    logic [NUM_REG-1:0][1:0] mode_w;
    logic [NUM_REG-1:0] en_w;
    logic [NUM_REG-1:0][11:0] mv_w;
    logic [NUM_RES-1:0] pin_off;
    logic [NUM_PHASE-1:0] ph_high;
    logic [15:0] gap_prod;
    logic [7:0] gap;
    logic [2:0] ridx;
    logic is_ctrl;
    logic is_volt;
    logic bus_commit;
    logic [31:0] rd_word;
    logic [31:0] wr_data;
    logic sync_edge;
    logic warm_edge;
    logic [7:0] sel_period;

    // ======================================================================
    // Helpers
    function automatic logic [11:0] volt_mv(input logic [7:0] v);
        logic [11:0] steps;
        steps = 12'(v[6:0]) - 12'h001;
        if (v[VOLT_RANGE_BIT]) begin
            return HI_BASE_MV + steps * HI_STEP_MV;
        end
        return LO_BASE_MV + steps * LO_STEP_MV;
    endfunction : volt_mv

    function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] be);
        logic [31:0] r;
        r = old_w;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_w[b*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // ======================================================================
    // Per-rail and per-resource decode
    generate
        for (genvar g = 0; g < NUM_RES; g++) begin : g_res
            // Sleep pin is active low, resource_enable_pin_one pin active high
            assign pin_off[g] = (q.slp_asg[g] & ~q.s2[SI_SLEEP]) |
                                (q.en1_asg[g] & ~q.s2[SI_EN1]);
        end
        for (genvar g = 0; g < NUM_REG; g++) begin : g_rail
            assign sel_sleep[g] = pin_off[g];
            // Each rail picks its own mode field
            assign mode_w[g] = sel_sleep[g] ?
                q.ctrl[g][CTRL_MSLP_LSB +: 2] :
                q.ctrl[g][CTRL_MACT_LSB +: 2];
            assign en_w[g] = q.ctrl[g][CTRL_EN_BIT] &
                             (mode_w[g] != MODE_OFF) &
                             (q.volt[g][6:0] != 7'h00) &
                             ~q.trip[g];
            assign mv_w[g] = volt_mv(q.volt[g]);
        end
    endgenerate

    // ======================================================================
    // Phase clock taps, spaced by about one ninth of the period
    assign gap_prod = 16'(q.period) * PHASE_MUL;
    assign gap = 8'(gap_prod >> PHASE_SHIFT);

    generate
        for (genvar k = 0; k < NUM_PHASE; k++) begin : g_phase
            logic [8:0] off;
            logic [8:0] raw;
            logic [8:0] diff;
            assign off = 9'(k) * {1'b0, gap};
            assign raw = {1'b0, q.phase_cnt} + {1'b0, q.period} - off;
            assign diff = (raw >= {1'b0, q.period}) ?
                raw - {1'b0, q.period} : raw;
            assign ph_high[k] = diff < {2'b00, q.period[7:1]};
        end
    endgenerate

    // ======================================================================
    // Bus decode and read mux
    assign ridx = bus_req.address[4:2];
    assign is_ctrl = (bus_req.address[7:5] == CTRL_BASE[7:5]) &&
                     (bus_req.address[1:0] == 2'h0) && (ridx != 3'h7);
    assign is_volt = (bus_req.address[7:5] == VOLT_BASE[7:5]) &&
                     (bus_req.address[1:0] == 2'h0) && (ridx != 3'h7);
    // Commit happens only on the edge where the master sees waitrequest low
    assign bus_commit = bus_req.write & ~q.rsp.waitrequest;
    assign sync_edge = q.s2[SI_SYNC] & ~q.sync_prev;
    assign warm_edge = q.s2[SI_WARM] & ~q.warm_prev;

    always_comb begin
        rd_word = 32'h0000_0000;
        if (is_ctrl) begin
            rd_word = {24'h00_0000, q.ctrl[ridx]};
        end else if (is_volt) begin
            rd_word = {24'h00_0000, q.volt[ridx]};
        end else begin
            unique case (bus_req.address)
                PD_OFFSET: rd_word = {25'h000_0000, q.pd};
                MON_OFFSET: rd_word = {29'h0000_0000, q.mon};
                SLP_ASG_OFFSET: rd_word = {21'h00_0000, q.slp_asg};
                EN1_ASG_OFFSET: rd_word = {21'h00_0000, q.en1_asg};
                STATUS_OFFSET: rd_word = {9'h000, q.trip, 4'h0,
                    q.seq == SEQ_DONE, q.sat_lo, q.sat_hi, q.sync_ok,
                    q.ok_flag, q.rail_ok};
                SYS_OFFSET: rd_word = {27'h000_0000, q.sys};
                default: rd_word = 32'h0000_0000; // Unmapped reads zero
            endcase
        end
    end

    assign wr_data = lane_merge(rd_word, bus_req.writedata,
                                bus_req.byteenable);

    // Sync clock period clamped to the supported band
    always_comb begin
        if (!q.sync_ok) begin
            sel_period = 8'(FALLBACK_CYC);
        end else if (q.last_period > PERIOD_LO_CYC) begin
            sel_period = 8'(PERIOD_LO_CYC);
        end else if (q.last_period < PERIOD_HI_CYC) begin
            sel_period = 8'(PERIOD_HI_CYC);
        end else begin
            sel_period = q.last_period[7:0];
        end
    end

    // ======================================================================
    // Next state
    always_comb begin
        n = q;

        // Pin synchronisers, first stage feeds only the second
        n.s1 = {switcher_sync_clock_in, supply_below_limit, warm_reset_pin,
                resource_enable_pin_one, sleep_request_pin_n};
        n.s2 = q.s1;
        n.win1 = rail_in_window;
        n.win2 = q.win1;
        n.sync_prev = q.s2[SI_SYNC];
        n.warm_prev = q.s2[SI_WARM];

        // One wait cycle, then a single answer cycle
        n.rsp.waitrequest = 1'b1;
        if ((bus_req.read | bus_req.write) && q.rsp.waitrequest) begin
            n.rsp.waitrequest = 1'b0;
            n.rsp.readdata = rd_word;
        end

        // Rail commands all refresh on one edge from settled registers
        for (int i = 0; i < NUM_REG; i++) begin
            n.cmd[i].enable = en_w[i];
            n.cmd[i].mode = mode_w[i];
            n.cmd[i].range = q.volt[i][VOLT_RANGE_BIT];
            n.cmd[i].volt_code = q.volt[i][6:0];
            n.cmd[i].discharge = q.pd[i] & ~en_w[i] &
                                 ~q.ctrl[i][CTRL_EN_BIT];
            n.cmd[i].ext_clock = (mode_w[i] == MODE_PWM) &
                                 q.sync_ok;
            n.cmd[i].adc_route = (q.mon == 3'(i));
            // Trip is set by hardware and held while mode stays quiet
            n.trip[i] = ((mode_w[i] == MODE_LQ) &&
                         (mv_w[i] > LQ_VOUT_LIMIT_MV) &&
                         q.s2[SI_SUPPLY]) ||
                        (q.trip[i] && (mode_w[i] == MODE_LQ));
            if (en_w[i] && !q.cmd[i].enable) begin
                n.blank[i] = BLANK_CYC;
            end else if (q.blank[i] != 12'h000) begin
                n.blank[i] = q.blank[i] - 12'h001;
            end
            n.rail_ok[i] = ~q.cmd[i].enable | (q.blank[i] != 12'h000) |
                           q.win2[i];
        end
        n.ok_flag = &q.rail_ok;

        // Other resources follow their pin assignment too
        n.clk32k_en = q.sys[SYS_CLK32K_BIT] &
                      ~pin_off[NUM_REG];
        for (int j = 0; j < 3; j++) begin
            n.gpo_en[j] = q.sys[SYS_GPO_LSB + j] &
                          ~pin_off[NUM_REG + 1 + j];
        end

        // Internal oscillator and its optional export
        n.rc_cnt = ({1'b0, q.rc_cnt} == FALLBACK_CYC - 9'h001) ?
            8'h00 : q.rc_cnt + 8'h01;
        n.rc_clk = {1'b0, q.rc_cnt} < (FALLBACK_CYC >> 1);
        n.pin5_oe = q.sys[SYS_PIN5_BIT];
        n.pin5_o = q.rc_clk & q.sys[SYS_PIN5_BIT];

        // Sync period measurement with loss timeout
        if (sync_edge) begin
            n.last_period = q.meas + 9'h001;
            n.meas = 9'h000;
            n.sync_ok = 1'b1;
        end else if (q.meas == SYNC_LOSS_CYC) begin
            n.sync_ok = 1'b0;
        end else begin
            n.meas = q.meas + 9'h001;
        end
        n.sat_hi = q.sync_ok & (q.last_period < PERIOD_HI_CYC);
        n.sat_lo = q.sync_ok & (q.last_period > PERIOD_LO_CYC);

        // New period taken only at wrap so no tap ever glitches short
        if ({1'b0, q.phase_cnt} >= {1'b0, q.period} - 9'h001) begin
            n.phase_cnt = 8'h00;
            n.period = sel_period;
        end else begin
            n.phase_cnt = q.phase_cnt + 8'h01;
        end
        n.sw_clk = ph_high;

        // Register writes
        if (bus_commit) begin
            if (is_ctrl) begin
                n.ctrl[ridx] = wr_data[7:0];
            end else if (is_volt) begin
                n.volt[ridx] = wr_data[7:0];
                if (wr_data[7:0] != q.volt[ridx]) begin
                    n.blank[ridx] = BLANK_CYC;
                end
            end else begin
                unique case (bus_req.address)
                    PD_OFFSET: n.pd = wr_data[6:0];
                    MON_OFFSET: n.mon = wr_data[2:0];
                    SLP_ASG_OFFSET: n.slp_asg = wr_data[10:0];
                    EN1_ASG_OFFSET: n.en1_asg = wr_data[10:0];
                    SYS_OFFSET: n.sys = wr_data[4:0];
                    default: n.sys = n.sys; // Read-only or unmapped
                endcase
            end
        end

        // Startup sequencer: sets enables in fuse-chosen slots
        unique case (q.seq)
            SEQ_RUN: begin
                if (q.slot_cyc == SLOT_CYC - 8'h01) begin
                    n.slot_cyc = 8'h00;
                    if (q.slot == SEQ_LAST_SLOT) begin
                        n.seq = SEQ_DONE;
                    end else begin
                        n.slot = q.slot + 3'h1;
                    end
                end else begin
                    n.slot_cyc = q.slot_cyc + 8'h01;
                end
                for (int i = 0; i < NUM_REG; i++) begin
                    if (q.slot_cyc == 8'h00 && otp_seq_en[i] &&
                        otp_slot[i] == q.slot &&
                        !q.ctrl[i][CTRL_RETAIN_BIT]) begin
                        n.ctrl[i][CTRL_EN_BIT] = 1'b1;
                    end
                end
            end
            SEQ_DONE: begin
                n.slot_cyc = 8'h00;
            end
            default: begin
                n.seq = SEQ_RUN;
            end
        endcase

        // Warm reset: reload rails whose retention bit is clear
        if (warm_edge) begin
            for (int i = 0; i < NUM_REG; i++) begin
                if (!q.ctrl[i][CTRL_RETAIN_BIT]) begin
                    n.ctrl[i] = CTRL_RESET;
                    n.volt[i] = otp_voltage[i];
                    n.trip[i] = 1'b0;
                    n.blank[i] = 12'h000;
                end
            end
            n.seq = SEQ_RUN;
            n.slot = 3'h0;
            n.slot_cyc = 8'h00;
        end

        // Synchronous reset; fuse defaults are sampled here
        if (rst) begin
            n = '0;
            n.ctrl = {NUM_REG{CTRL_RESET}};
            n.volt = otp_voltage;
            n.pd = PD_RESET;
            n.mon = MON_RESET;
            n.slp_asg = ASG_RESET;
            n.en1_asg = ASG_RESET;
            n.sys = SYS_RESET;
            n.seq = SEQ_RUN;
            n.period = 8'(FALLBACK_CYC);
            n.rsp.waitrequest = 1'b1;
        end
    end

    // Single state register
    always_ff @(posedge ref_clk) begin
        q <= n;
    end

    // ======================================================================
    // Outputs, all straight from flip-flops
    assign bus_rsp = q.rsp;
    assign reg_cmd = q.cmd;
    assign phase_clk = q.sw_clk;
    assign output_ok_flag = q.ok_flag;
    assign clk32k_enable = q.clk32k_en;
    assign gpo_enable = q.gpo_en;
    assign general_pin_five_o = q.pin5_o;
    assign general_pin_five_oe = q.pin5_oe;

endmodule : regulator_control

/* shared/regulator_control_pkg.sv */
// Shared constants, register map and carrier types for regulator control
package regulator_control_pkg;

    // ======================================================================
    // Sizes
    localparam int NUM_REG = 7;
    localparam int NUM_PHASE = 9;
    localparam int NUM_RES = 11; // Rails, then 32 kHz clock, then 3 outputs

    // ======================================================================
    // Register offsets (byte addresses, one word each)
    localparam logic [7:0] CTRL_BASE = 8'h00;
    localparam logic [7:0] VOLT_BASE = 8'h20;
    localparam logic [7:0] PD_OFFSET = 8'h40;
    localparam logic [7:0] MON_OFFSET = 8'h44;
    localparam logic [7:0] SLP_ASG_OFFSET = 8'h48;
    localparam logic [7:0] EN1_ASG_OFFSET = 8'h4C;
    localparam logic [7:0] STATUS_OFFSET = 8'h50;
    localparam logic [7:0] SYS_OFFSET = 8'h54;

    // ======================================================================
    // Field positions
    localparam int CTRL_MACT_LSB = 0;
    localparam int CTRL_MSLP_LSB = 2;
    localparam int CTRL_EN_BIT = 4;
    localparam int CTRL_RETAIN_BIT = 5;
    localparam int VOLT_RANGE_BIT = 7;
    localparam int SYS_CLK32K_BIT = 0;
    localparam int SYS_GPO_LSB = 1;
    localparam int SYS_PIN5_BIT = 4;

    // ======================================================================
    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h01;
    localparam logic [6:0] PD_RESET = 7'h7F;
    localparam logic [2:0] MON_RESET = 3'h7;
    localparam logic [10:0] ASG_RESET = 11'h000;
    localparam logic [4:0] SYS_RESET = 5'h01;

    // ======================================================================
    // Operating mode codes
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    localparam logic [1:0] MODE_LQ = 2'h2;

    // ======================================================================
    // Output voltage scale, millivolts
    localparam logic [11:0] LO_BASE_MV = 12'd500;
    localparam logic [11:0] LO_STEP_MV = 12'd10;
    localparam logic [11:0] HI_BASE_MV = 12'd1000;
    localparam logic [11:0] HI_STEP_MV = 12'd20;
    localparam logic [11:0] LQ_VOUT_LIMIT_MV = 12'd2800;

    // ======================================================================
    // Timing
    localparam int CLK_KHZ = 200000;
    localparam int SYNC_LO_KHZ = 1700;
    localparam int SYNC_HI_KHZ = 2700;
    localparam int FALLBACK_KHZ = 2200;
    localparam logic [8:0] PERIOD_LO_CYC = 9'(CLK_KHZ / SYNC_LO_KHZ);
    localparam logic [8:0] PERIOD_HI_CYC =
        9'((CLK_KHZ + SYNC_HI_KHZ - 1) / SYNC_HI_KHZ);
    localparam logic [8:0] FALLBACK_CYC = 9'(CLK_KHZ / FALLBACK_KHZ);
    localparam logic [8:0] SYNC_LOSS_CYC = 9'(4 * (CLK_KHZ / SYNC_LO_KHZ));
    localparam int SLOT_TIME_NS = 1000;
    localparam logic [7:0] SLOT_CYC = 8'(SLOT_TIME_NS * CLK_KHZ / 1000000);
    localparam int BLANK_TIME_NS = 10000;
    localparam logic [11:0] BLANK_CYC =
        12'(BLANK_TIME_NS * CLK_KHZ / 1000000);
    localparam logic [2:0] SEQ_LAST_SLOT = 3'h7;
    localparam logic [15:0] PHASE_MUL = 16'h0039; // About 1/9 after shift
    localparam int PHASE_SHIFT = 9;

    // ======================================================================
    // Types
    typedef enum logic [1:0] {
        SEQ_RUN = 2'b01,
        SEQ_DONE = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } avm_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avm_rsp_t;

    typedef struct packed {
        logic enable;
        logic [1:0] mode;
        logic range;
        logic [6:0] volt_code;
        logic discharge;
        logic ext_clock;
        logic adc_route;
    } reg_cmd_t;

endpackage : regulator_control_pkg

/* verif/regulator_control_monitor.sv */
// Port checker for the regulator control block
`timescale 1ns/1ps
module regulator_control_monitor
    import regulator_control_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire avm_req_t bus_req,
    input wire avm_rsp_t bus_rsp,
    input wire logic supply_below_limit,
    input wire reg_cmd_t [NUM_REG-1:0] reg_cmd,
    input wire logic [NUM_PHASE-1:0] phase_clk,
    input wire logic output_ok_flag
);
    // ====================
    // Helpers
    logic [NUM_REG-1:0] en, zc, dc, ex, pw, rt;
    logic hot, p0_q, seen_q;
    logic [8:0] cnt_q;
    // Rail flags as vectors keep each check to one line
    always_comb begin
        for (int i = 0; i < NUM_REG; i++) begin
            en[i] = reg_cmd[i].enable;
            zc[i] = reg_cmd[i].volt_code == 7'h00;
            dc[i] = reg_cmd[i].discharge;
            ex[i] = reg_cmd[i].ext_clock;
            pw[i] = reg_cmd[i].mode == MODE_PWM;
            rt[i] = reg_cmd[i].adc_route;
        end
    end
    // Rail 0 above 2.8 V in low-quiescent mode on a weak supply
    assign hot = supply_below_limit && reg_cmd[0].mode == MODE_LQ &&
        reg_cmd[0].range && reg_cmd[0].volt_code >= 7'h5C;
    // Cycles since the last rise of the first phase clock
    always_ff @(posedge ref_clk) begin
        p0_q <= phase_clk[0];
        if (rst) begin
            seen_q <= 1'b0;
            cnt_q <= 9'h000;
        end else if (phase_clk[0] && !p0_q) begin
            seen_q <= 1'b1;
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_q + 9'h001;
        end
    end
    // ====================
    // Assertions
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    chk_wait_answer: assert property ((bus_req.read || bus_req.write) &&
        bus_rsp.waitrequest |=> !bus_rsp.waitrequest) else $error("late");
    chk_wait_single: assert property ($fell(bus_rsp.waitrequest) |=>
        bus_rsp.waitrequest) else $error("waitrequest low too long");
    chk_off_code: assert property ((en & zc) == '0)
        else $error("rail on with zero code");
    chk_discharge_off: assert property ((dc & en) == '0)
        else $error("discharge on an enabled rail");
    chk_ext_pwm: assert property ((ex & ~pw) == '0)
        else $error("sync clock outside forced PWM");
    chk_route_one: assert property ($onehot0(rt))
        else $error("more than one rail routed");
    chk_ok_blank: assert property ((en == '0) [*8] |-> output_ok_flag)
        else $error("good flag low with all rails off");
    chk_low_trip: assert property (hot [*8] |-> !reg_cmd[0].enable)
        else $error("no trip on low supply");
    chk_active_mode: assert property (bus_req.write &&
        !bus_rsp.waitrequest && bus_req.address == CTRL_BASE &&
        bus_req.writedata[1:0] != 2'h3 |=> ##1
        reg_cmd[0].mode == $past(bus_req.writedata[1:0], 2))
        else $error("active mode not applied");
    chk_phase_apart: assert property ($rose(phase_clk[0]) |->
        !$rose(phase_clk[1])) else $error("phases coincide");
    chk_sw_period: assert property (seen_q && phase_clk[0] && !p0_q |->
        cnt_q >= 9'h04A && cnt_q <= 9'h074) else $error("period off band");
endmodule : regulator_control_monitor

bind regulator_control regulator_control_monitor mon (.ref_clk(ref_clk),
    .rst(rst), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .supply_below_limit(supply_below_limit), .reg_cmd(reg_cmd),
    .phase_clk(phase_clk), .output_ok_flag(output_ok_flag));

/* verif/sync_clock_source.sv */
// External sync clock source model
`timescale 1ns/1ps
module sync_clock_source (
    input wire logic [15:0] half_ns,
    output logic sync_o
);
    // Zero half period grounds the pin; offset keeps phase off the clock
    initial begin
        sync_o = 1'b0;
        #1.3;
        forever begin
            if (half_ns == 16'h0000) begin
                sync_o = 1'b0;
                #10;
            end else begin
                #(half_ns);
                sync_o = ~sync_o;
            end
        end
    end
endmodule : sync_clock_source

/* verif/tb_top.sv */
// Self-checking bench for the regulator control block
`timescale 1ns/1ps
module tb_top;
    import regulator_control_pkg::*;
    // ====================
    // Bench state
    typedef struct packed {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] e;
    } row_t;
    row_t rows [6] = '{'{8'h08, 32'hFFFF_FFFF, 32'hFF},
        '{8'h24, 32'h1234_5685, 32'h85}, '{8'h40, 32'hFFFF_FF2A, 32'h2A},
        '{8'h44, 32'h3, 32'h3}, '{8'h4C, 32'hFFFF_FFFF, 32'h7FF},
        '{8'h80, 32'hFFFF, 32'h0}};
    logic ref_clk, rst, slp_n, en1, wrst, sync, below, okf, c32, p5oe, p5o;
    logic [6:0] win;
    logic [15:0] half_ns;
    logic [8:0] ph;
    logic [2:0] gpo;
    logic [31:0] rd;
    avm_req_t breq;
    avm_rsp_t rsp;
    reg_cmd_t [NUM_REG-1:0] cmd;
    int check_count, bad_count, n;
    regulator_control uut (.ref_clk(ref_clk), .rst(rst), .bus_req(breq),
        .bus_rsp(rsp), .otp_voltage({NUM_REG{8'h32}}), .otp_seq_en(7'h40),
        .otp_slot({NUM_REG{3'h1}}), .sleep_request_pin_n(slp_n),
        .resource_enable_pin_one(en1), .warm_reset_pin(wrst),
        .switcher_sync_clock_in(sync), .supply_below_limit(below),
        .rail_in_window(win), .reg_cmd(cmd), .phase_clk(ph),
        .output_ok_flag(okf), .clk32k_enable(c32), .gpo_enable(gpo),
        .general_pin_five_o(p5o), .general_pin_five_oe(p5oe));
    sync_clock_source src (.half_ns(half_ns), .sync_o(sync));
    // ====================
    // Tasks
    // Bus cycle held until waitrequest is seen low, then an idle edge
    task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        breq <= '{read: !w, write: w, address: a, writedata: d,
            byteenable: 4'hF};
        do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
        rd = rsp.readdata;
        breq <= '0;
        @(posedge ref_clk);
    endtask : acc
    task wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
        repeat (4) @(posedge ref_clk);
    endtask : wr
    task cmp(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task rdc(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h0);
        cmp(rd, e);
    endtask : rdc
    task complete_run;
        if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : complete_run
    // ====================
    // Clock and watchdog; a hang ends the run as a failure
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        bad_count++;
        complete_run();
    end
    // ====================
    // Main sequence
    initial begin
        {rst, slp_n, en1, wrst, below, win, half_ns} = {5'h1C, 7'h7F,
            16'h0};
        breq = '0;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        foreach (rows[i]) begin
            acc(1'b1, rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        cmp(cmd[3].adc_route, 1'b1);
        rst <= 1'b1; // Second reset in mid-run
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rdc(CTRL_BASE, 32'h01);
        rdc(VOLT_BASE + 8'h0C, 32'h32);
        rdc(PD_OFFSET, 32'h7F);
        rdc(EN1_ASG_OFFSET, 32'h0);
        half_ns <= 16'd250;
        repeat (1000) @(posedge ref_clk);
        acc(1'b0, STATUS_OFFSET, 32'h0);
        cmp(rd[10:8], 3'h1);
        wr(CTRL_BASE, 32'h11);
        wr(VOLT_BASE, 32'h0);
        cmp({cmd[0].enable, cmd[0].discharge}, 2'h0);
        wr(VOLT_BASE, 32'hFF);
        cmp({cmd[0].enable, cmd[0].mode, cmd[0].ext_clock}, 4'hB);
        wr(CTRL_BASE, 32'h12); // Low-quiescent entered after enabling
        cmp({cmd[0].enable, cmd[0].ext_clock}, 2'h2);
        below <= 1'b1;
        repeat (10) @(posedge ref_clk);
        below <= 1'b0;
        repeat (10) @(posedge ref_clk);
        cmp(cmd[0].enable, 1'b0);
        wr(CTRL_BASE, 32'h01);
        cmp({cmd[0].enable, cmd[0].discharge}, 2'h1);
        half_ns <= 16'd100;
        repeat (1500) @(posedge ref_clk);
        rdc(STATUS_OFFSET, 32'hBFF);
        cmp(rd[10:9], 2'h1);
        half_ns <= 16'd500;
        repeat (1500) @(posedge ref_clk);
        acc(1'b0, STATUS_OFFSET, 32'h0);
        cmp(rd[10:9], 2'h2);
        half_ns <= 16'h0;
        repeat (1000) @(posedge ref_clk);
        // Phase clock period counted between two rises, bounded
        n = 0;
        rd = '1;
        repeat (400) begin
            @(posedge ref_clk);
            if (n > 0) n++;
            if (ph[0] && !rd[0]) begin
                if (n > 0) break;
                n = 1;
            end
            rd[0] = ph[0];
        end
        cmp(n - 1, 32'(FALLBACK_CYC));
        cmp({p5oe, p5o}, 2'h0);
        wr(SYS_OFFSET, 32'h1F);
        cmp({p5oe, gpo, c32}, 5'h1F);
        wr(EN1_ASG_OFFSET, 32'h80);
        en1 <= 1'b0;
        repeat (8) @(posedge ref_clk);
        cmp(c32, 1'b0);
        win <= 7'h3F;
        repeat (8) @(posedge ref_clk);
        cmp(okf, 1'b0);
        win <= 7'h5F;
        repeat (8) @(posedge ref_clk);
        cmp(okf, 1'b1);
        wr(VOLT_BASE + 8'h18, 32'h40);
        win <= 7'h3F;
        repeat (8) @(posedge ref_clk);
        cmp(okf, 1'b1);
        wr(CTRL_BASE + 8'h08, 32'h20);
        wr(VOLT_BASE + 8'h08, 32'h40);
        wr(VOLT_BASE + 8'h0C, 32'h40);
        wrst <= 1'b1;
        repeat (6) @(posedge ref_clk);
        wrst <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rdc(VOLT_BASE + 8'h08, 32'h40);
        rdc(VOLT_BASE + 8'h0C, 32'h32);
        repeat (1700) @(posedge ref_clk);
        cmp({cmd[6].enable, cmd[5].enable}, 2'h2);
        wr(SLP_ASG_OFFSET, 32'h1);
        wr(CTRL_BASE, 32'h19);
        slp_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        cmp(cmd[0].mode, 2'h2);
        complete_run();
    end
endmodule : tb_top
